/* rtl/pls_synth_core.sv */
`timescale 1ns/100ps
// digital core of the serially programmed synthesizer
module pls_synth_core
   import pls_pkg::*;
(
   input  wire logic clk_i,                    // core clock, 250 MHz
   input  wire logic rst_i,                    // async reset, active high
   input  wire logic ser_clk_i,                // host shift clock
   input  wire logic ser_data_i,               // host serial data
   input  wire logic load_strobe_i,            // load strobe pin
   input  wire logic phase_polarity_select_i,  // detector polarity pin
   input  wire logic ref_osc_i,                // reference oscillator level
   input  wire logic vco_i,                    // vco input level
   output logic      fb_side_pulse_out_o,      // feedback side detector output
   output logic      ref_side_pulse_out_o,     // reference side detector output
   output logic      charge_pump_out_o,        // main pump level
   output logic      charge_pump_oe_o,         // main pump drive enable
   output logic      bypass_pump_out_o,        // bypass pump level
   output logic      bypass_pump_oe_o,         // bypass pump drive enable
   output logic      lock_indicator_o,         // high while no error pulse
   output logic      compare_monitor_out_o     // divider monitor
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [PIN_W-1:0]        pin_raw;           // pins gathered
   logic [PIN_W-1:0]        pin_meta;          // first stage, read by second only
   logic [PIN_W-1:0]        pin_sync;          // second stage
   logic [PIN_W-1:0]        pin_prev;          // delayed for edge detection
   logic                    strobe_s;          // synced load strobe
   logic                    pol_s;             // synced polarity
   logic                    strobe_rise;       // load moment
   logic                    ref_rise;          // reference input edge
   logic                    vco_rise;          // vco input edge
   logic [SHIFT_W-1:0]      shift_word;        // from link domain
   logic [REF_LATCH_W-1:0]  ref_latch;         // reference divider latch
   logic [MAIN_LATCH_W-1:0] main_latch;        // main divider latch
   logic [REF_RATIO_W-1:0]  ref_ratio;         // decoded reference ratio
   logic                    presc_sel;         // prescaler select
   logic [SWALLOW_W-1:0]    swallow_count;     // decoded swallow count
   logic [MAIN_RATIO_W-1:0] main_ratio;        // decoded main ratio
   logic [REF_RATIO_W-1:0]  ref_cnt;           // reference counter
   logic                    ref_sig;           // reference compare signal
   logic                    ref_sig_prev;      // for leading edge
   logic [PRESC_CNT_W-1:0]  presc_base;        // 64 or 128
   logic [PRESC_CNT_W-1:0]  presc_mod;         // modulus of current cycle
   logic [PRESC_CNT_W-1:0]  presc_cnt;         // prescaler counter
   logic                    presc_tick;        // prescaler cycle done
   logic [SWALLOW_W-1:0]    swal_cnt;          // swallow cycles left
   logic [MAIN_RATIO_W-1:0] main_cnt;          // main counter
   logic                    fb_wrap;           // end of one feedback period
   logic                    fb_sig;            // feedback compare signal
   logic                    fb_sig_prev;       // for leading edge
   logic                    ref_edge;          // detector reference event
   logic                    fb_edge;           // detector feedback event
   logic                    up_q;              // reference ahead: raise vco
   logic                    down_q;            // feedback ahead: lower vco
   logic                    next_pump;         // pump level from polarity
   logic                    next_drive;        // exactly one side active

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; strobe and polarity rest high so an open pin reads high
   assign pin_raw = {load_strobe_i, phase_polarity_select_i, ref_osc_i, vco_i};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_meta <= PIN_RST;
         pin_sync <= PIN_RST;
         pin_prev <= PIN_RST;                  // no false load edge at release
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign strobe_s    = pin_sync[PIN_STROBE];
   assign pol_s       = pin_sync[PIN_POL];
   assign strobe_rise = rise_edge(pin_sync[PIN_STROBE], pin_prev[PIN_STROBE]);
   // inputs are sampled, so each must stay below half the core clock rate
   assign ref_rise    = rise_edge(pin_sync[PIN_REF], pin_prev[PIN_REF]);
   assign vco_rise    = rise_edge(pin_sync[PIN_VCO], pin_prev[PIN_VCO]);

   ////////////////////////////////////////////////////////////////////////////
   // serial port on the link clock
   pls_serial_port u_serial (
      .ser_clk_i    (ser_clk_i),
      .rst_i        (rst_i),
      .ser_data_i   (ser_data_i),
      .shift_word_o (shift_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // latch transfer: the word is read only at the third core clock edge after the strobe
   // rises, when shifting has finished and the bits have long settled
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_latch <= REF_LATCH_RST;
      end else if (strobe_rise && shift_word[TARGET_POS]) begin
         ref_latch <= shift_word[PAYLOAD_LSB +: REF_LATCH_W];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         main_latch <= MAIN_LATCH_RST;
      end else if (strobe_rise && !shift_word[TARGET_POS]) begin
         main_latch <= shift_word[PAYLOAD_LSB +: MAIN_LATCH_W];
      end
   end

   // field decode; ratios outside their ranges give undefined division
   assign ref_ratio     = ref_latch[REF_RATIO_LSB +: REF_RATIO_W];
   assign presc_sel     = ref_latch[PRESC_SEL_POS];
   assign swallow_count = main_latch[SWALLOW_LSB +: SWALLOW_W];
   assign main_ratio    = main_latch[MAIN_RATIO_LSB +: MAIN_RATIO_W];

   ////////////////////////////////////////////////////////////////////////////
   // reference divider
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_cnt <= '0;
      end else if (ref_rise) begin
         if (REF_RATIO_W'(ref_cnt + 14'h0001) >= ref_ratio) begin
            ref_cnt <= '0;                     // period complete
         end else begin
            ref_cnt <= REF_RATIO_W'(ref_cnt + 14'h0001);
         end
      end
   end

   // high for the first half of the period; leading edge at wrap
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_sig      <= 1'b0;
         ref_sig_prev <= 1'b0;
      end else begin
         ref_sig      <= (ref_cnt < (ref_ratio >> 1));
         ref_sig_prev <= ref_sig;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dual modulus prescaler: one extra count while swallow cycles remain
   assign presc_base = presc_sel ? PRESC_LOW : PRESC_HIGH;
   assign presc_mod  = PRESC_CNT_W'(presc_base + {7'h00, (swal_cnt != '0)});
   assign presc_tick = vco_rise && (PRESC_CNT_W'(presc_cnt + 8'h01) >= presc_mod);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         presc_cnt <= '0;
      end else if (presc_tick) begin
         presc_cnt <= '0;
      end else if (vco_rise) begin
         presc_cnt <= PRESC_CNT_W'(presc_cnt + 8'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse swallow: first swallow cycles at modulus+1, the rest at modulus
   assign fb_wrap = presc_tick &&
                    (MAIN_RATIO_W'(main_cnt + 11'h001) >= main_ratio);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         main_cnt <= '0;
      end else if (fb_wrap) begin
         main_cnt <= '0;
      end else if (presc_tick) begin
         main_cnt <= MAIN_RATIO_W'(main_cnt + 11'h001);
      end
   end

   // swallow must be below the main ratio or the extra counts never end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         swal_cnt <= '0;
      end else if (fb_wrap) begin
         swal_cnt <= swallow_count;
      end else if (presc_tick && (swal_cnt != '0)) begin
         swal_cnt <= SWALLOW_W'(swal_cnt - 7'h01);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fb_sig      <= 1'b0;
         fb_sig_prev <= 1'b0;
      end else begin
         fb_sig      <= (main_cnt < (main_ratio >> 1));
         fb_sig_prev <= fb_sig;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // phase frequency detector: only leading edges count, so duty is irrelevant
   assign ref_edge = rise_edge(ref_sig, ref_sig_prev);
   assign fb_edge  = rise_edge(fb_sig, fb_sig_prev);

   // both set clears both; an edge in the clearing cycle is kept, not lost
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         up_q   <= 1'b0;
         down_q <= 1'b0;
      end else if (up_q && down_q) begin
         up_q   <= ref_edge;
         down_q <= fb_edge;
      end else begin
         up_q   <= up_q | ref_edge;
         down_q <= down_q | fb_edge;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output stage, registered; polarity swaps detector and pump together
   assign next_pump  = pol_s ? up_q : down_q;
   assign next_drive = up_q ^ down_q;          // coincidence leaves pump off

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fb_side_pulse_out_o  <= 1'b1;
         ref_side_pulse_out_o <= 1'b0;
      end else begin
         fb_side_pulse_out_o  <= ~(pol_s ? up_q : down_q);
         ref_side_pulse_out_o <= pol_s ? down_q : up_q;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         charge_pump_out_o <= 1'b0;
         charge_pump_oe_o  <= 1'b0;
         bypass_pump_out_o <= 1'b0;
         bypass_pump_oe_o  <= 1'b0;
      end else begin
         charge_pump_out_o <= next_pump;
         charge_pump_oe_o  <= next_drive;
         bypass_pump_out_o <= next_pump;
         bypass_pump_oe_o  <= next_drive & strobe_s;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_indicator_o      <= 1'b1;
         compare_monitor_out_o <= 1'b0;
      end else begin
         lock_indicator_o      <= ~(up_q | down_q);
         compare_monitor_out_o <= pol_s ? ref_sig : fb_sig;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // period helper: counts vco edges between wraps once config is stable
   logic [PERIOD_W-1:0] period_cnt;            // edges since last wrap
   logic [PERIOD_W-1:0] period_expect;         // modulus*main + swallow
   logic                period_armed;          // full stable period observed

   assign period_expect = PERIOD_W'(PERIOD_W'(presc_base) * PERIOD_W'(main_ratio)) +
                          PERIOD_W'(swallow_count);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         period_cnt   <= '0;
         period_armed <= 1'b0;
      end else begin
         if (fb_wrap) begin
            period_cnt <= '0;
         end else if (vco_rise) begin
            period_cnt <= PERIOD_W'(period_cnt + 19'h00001);
         end
         if (strobe_rise) begin
            period_armed <= 1'b0;
         end else if (fb_wrap) begin
            period_armed <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence both_set_s;
      up_q && down_q;
   endsequence

   sequence ref_only_s;
      up_q && !down_q;
   endsequence

   sequence fb_only_s;
      down_q && !up_q;
   endsequence

   feedback_period_a: assert property (
      fb_wrap && period_armed && !strobe_rise |->
      PERIOD_W'(period_cnt + 19'h00001) == period_expect)
      else $error("feedback period differs from programmed ratio");

   ref_latch_load_a: assert property (
      strobe_rise && shift_word[TARGET_POS] |=>
      ref_latch == $past(shift_word[PAYLOAD_LSB +: REF_LATCH_W]))
      else $error("reference latch not loaded from shift word");

   main_latch_load_a: assert property (
      strobe_rise && !shift_word[TARGET_POS] |=>
      main_latch == $past(shift_word[PAYLOAD_LSB +: MAIN_LATCH_W]) &&
      $stable(ref_latch))
      else $error("main latch not loaded from shift word");

   pfd_reset_a: assert property (
      both_set_s |=> (up_q == $past(ref_edge)) && (down_q == $past(fb_edge)))
      else $error("detector did not clear after both sides set");

   pfd_arm_a: assert property (
      ref_edge && !down_q |=> (up_q && down_q) or up_q [*2])
      else $error("reference edge did not arm detector");

   fast_fb_out_a: assert property (
      fb_only_s and pol_s |=> fb_side_pulse_out_o && ref_side_pulse_out_o &&
      charge_pump_oe_o && !charge_pump_out_o)
      else $error("wrong outputs for fast feedback, polarity high");

   slow_fb_out_a: assert property (
      ref_only_s and pol_s |=> !fb_side_pulse_out_o && !ref_side_pulse_out_o &&
      charge_pump_out_o)
      else $error("wrong outputs for slow feedback, polarity high");

   reversed_out_a: assert property (
      fb_only_s and !pol_s |=> !fb_side_pulse_out_o && !ref_side_pulse_out_o &&
      charge_pump_out_o)
      else $error("wrong outputs for fast feedback, polarity low");

   locked_out_a: assert property (
      !up_q && !down_q |=> fb_side_pulse_out_o && !ref_side_pulse_out_o &&
      !charge_pump_oe_o && lock_indicator_o)
      else $error("idle detector outputs wrong");

   bypass_follow_a: assert property (
      1 |=> (bypass_pump_oe_o == (charge_pump_oe_o && $past(strobe_s))) &&
            (bypass_pump_out_o == charge_pump_out_o))
      else $error("bypass pump does not follow main pump");

   lock_nor_a: assert property (
      (up_q || down_q) ##1 (up_q || down_q) |-> !lock_indicator_o)
      else $error("lock indicator high during error pulse");

   monitor_mux_a: assert property (
      $stable(pol_s) |=>
      compare_monitor_out_o == ($past(pol_s) ? $past(ref_sig) : $past(fb_sig)))
      else $error("monitor shows wrong compare signal");

endmodule

/* include/pls_pkg.sv */
// Overview of operation
// - each shift clock rise shifts one bit
// - strobe high copies shift word into latch; the code copies only once, at the strobe rise
// - target bit high loads reference latch
// - target bit low loads main latch
// - select 0 gives 128/129, 1 gives 64/65
// - feedback period is modulus*main plus swallow
// - detector acts on leading edges only
// - polarity high, feedback fast: ref side pulses
// - polarity high, feedback slow: fb side pulses
// - polarity low, feedback fast: fb side pulses
// - polarity low, feedback slow: ref side pulses
// - locked: fb side high, ref side low
// - pulse width grows with phase error
// - polarity flips detector and pump together
// - monitor shows reference or feedback by polarity
// - strobe high: bypass pump mirrors main pump
// - lock indicator is nor of up, down
// - strobe low: bypass pump high impedance
// - open strobe input reads as high
// - open polarity input reads as high
package pls_pkg;

   // shift register and latch geometry
   localparam int SHIFT_W        = 19;  // longest serial word
   localparam int REF_LATCH_W    = 15;  // reference latch width
   localparam int MAIN_LATCH_W   = 18;  // main latch width
   localparam int REF_RATIO_W    = 14;  // reference divide ratio
   localparam int MAIN_RATIO_W   = 11;  // main counter ratio
   localparam int SWALLOW_W      = 7;   // swallow counter
   localparam int PRESC_CNT_W    = 8;   // prescaler counter width
   localparam int PERIOD_W       = 19;  // one feedback period in input edges

   // field positions
   localparam int TARGET_POS      = 0;  // last bit shifted in
   localparam int PAYLOAD_LSB     = 1;  // latch payload starts above target
   localparam int REF_RATIO_LSB   = 0;  // within reference latch
   localparam int PRESC_SEL_POS   = 14; // within reference latch
   localparam int SWALLOW_LSB     = 0;  // within main latch
   localparam int MAIN_RATIO_LSB  = 7;  // within main latch

   // synchronised pin vector positions
   localparam int PIN_VCO    = 0;
   localparam int PIN_REF    = 1;
   localparam int PIN_POL    = 2;
   localparam int PIN_STROBE = 3;
   localparam int PIN_W      = 4;

   // pins with pull-ups rest high while reset holds
   localparam logic [PIN_W-1:0] PIN_RST = 4'hC;

   // prescaler base moduli
   localparam logic [PRESC_CNT_W-1:0] PRESC_HIGH = 8'h80; // select 0
   localparam logic [PRESC_CNT_W-1:0] PRESC_LOW  = 8'h40; // select 1

   // latch contents after reset: ratio 8 with 128/129, main 16 swallow 0
   localparam logic [REF_LATCH_W-1:0]  REF_LATCH_RST  = 15'h0008;
   localparam logic [MAIN_LATCH_W-1:0] MAIN_LATCH_RST = 18'h00800;

   // rising edge of a sampled level
   function automatic logic rise_edge(input logic cur, input logic prev);
      rise_edge = cur & ~prev;
   endfunction

endpackage

/* rtl/pls_serial_port.sv */
`timescale 1ns/100ps
// shift register on the host's shift clock; this clock stops between words
module pls_serial_port
   import pls_pkg::*;
(
   input  wire logic               ser_clk_i,    // host shift clock
   input  wire logic               rst_i,        // async reset, active high
   input  wire logic               ser_data_i,   // serial data, valid at shift edge
   output logic [SHIFT_W-1:0]      shift_word_o  // last bits shifted, newest in bit 0
);

   ////////////////////////////////////////////////////////////////////////////
   // shift in one bit per rising edge, msb first so the target bit lands at bit 0
   always_ff @(posedge ser_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_word_o <= '0;
      end else begin
         shift_word_o <= {shift_word_o[SHIFT_W-2:0], ser_data_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks on the link side
   shift_one_bit_a: assert property (
      @(posedge ser_clk_i) disable iff (rst_i)
      1 |=> (shift_word_o[0] == $past(ser_data_i)) &&
            (shift_word_o[SHIFT_W-1:1] == $past(shift_word_o[SHIFT_W-2:0])))
      else $error("shift register did not advance by one bit");

endmodule

/* dv/pls_host_model.sv */
`timescale 1ns/100ps
///////////////////////////////////////////////////////////////
// host side of the three-wire port; shift clock stands still between words
module pls_host_model (
   input  wire logic clk_i,      // core clock, paces the strobe
   output logic      ser_clk_o,  // shift clock, idle low
   output logic      ser_data_o, // serial data
   output logic      strobe_o    // load strobe
);
   // strobe rests high as the pull-up would hold it
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
      strobe_o = 1'b1;
   end
   // n bits, msb first, target bit last, strobe low meanwhile
   task automatic shift(input int n, input logic [18:0] w);
      @(negedge clk_i);
      strobe_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         ser_data_o = w[i];
         #13 ser_clk_o = 1'b1;
         #24 ser_clk_o = 1'b0;
         #11;
      end
      ser_data_o = ~w[0]; // released line must not keep the last bit
      repeat (6) @(negedge clk_i);
      strobe_o = 1'b1;
      repeat (6) @(negedge clk_i); // no shifting right after a load
   endtask
   // reference word: select, ratio, target high
   task automatic send_ref(input logic [15:0] w);
      shift(16, {3'h0, w});
   endtask
   // main word: ratio, swallow, target low
   task automatic send_main(input logic [18:0] w);
      shift(19, w);
   endtask
   // strobe low parks the bypass pump
   task automatic drop_strobe();
      strobe_o = 1'b0;
   endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
   logic clk_i = 1'b0;    // core clock
   logic rst_i = 1'b1;    // reset, held at start
   logic pol = 1'b1;      // polarity pin, pulled up
   logic ref_osc = 1'b0;  // reference oscillator
   logic vco = 1'b0;      // vco level, period 4 clk
   logic ser_clk, ser_data, strobe;                  // host port
   logic fb_side, ref_side, cp, cp_oe, bp, bp_oe, lock, mon; // core outputs
   int   n_errors = 0;    // mismatches
   int   checks_done = 0; // comparisons
   int   cyc = 0;         // cycle count, also the hang limit
   int   rhalf = 4;       // reference half period in clk
   int   rc = 0;          // reference phase count
   int   cnt[5];          // ref high, fb low, pump up, pump down, bypass wrong
   int   q[$];            // expected monitor periods in clk
   always #2 clk_i = ~clk_i;
   ///////////////////////////////////////////////////////////////
   pls_host_model pls_host_model_inst (.clk_i(clk_i), .ser_clk_o(ser_clk),
      .ser_data_o(ser_data), .strobe_o(strobe));
   pls_synth_core pls_synth_core_inst (.clk_i(clk_i), .rst_i(rst_i), .ser_clk_i(ser_clk),
      .ser_data_i(ser_data), .load_strobe_i(strobe), .phase_polarity_select_i(pol),
      .ref_osc_i(ref_osc), .vco_i(vco), .fb_side_pulse_out_o(fb_side),
      .ref_side_pulse_out_o(ref_side), .charge_pump_out_o(cp), .charge_pump_oe_o(cp_oe),
      .bypass_pump_out_o(bp), .bypass_pump_oe_o(bp_oe), .lock_indicator_o(lock),
      .compare_monitor_out_o(mon));
   ///////////////////////////////////////////////////////////////
   // sources move at the falling edge; the count also cuts a hang short
   always @(negedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc % 2 == 1) vco <= ~vco;
      if (rc + 1 >= rhalf) begin
         rc <= 0;
         ref_osc <= ~ref_osc;
      end else begin
         rc <= rc + 1;
      end
      if (cyc == 99000) begin
         n_errors++;
         end_sim();
      end
   end
   // tally detector and pump activity over a window
   always @(posedge clk_i) begin
      if (ref_side === 1'b1) cnt[0]++;
      if (fb_side === 1'b0) cnt[1]++;
      if (cp_oe === 1'b1 && cp === 1'b1) cnt[2]++;
      if (cp_oe === 1'b1 && cp === 1'b0) cnt[3]++;
      if (bp_oe !== (cp_oe & strobe) || (bp_oe === 1'b1 && bp !== cp)) cnt[4]++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // settle, tally a window; dn means the pump should pull low
   // coincident edges may glitch the quiet side, so a little slack
   task automatic det(input logic dn);
      repeat (20) @(negedge clk_i);
      cnt = '{default: 0};
      repeat (5000) @(negedge clk_i);
      check({cnt[dn ? 1 : 0] <= 2, cnt[dn ? 0 : 1] > 2, cnt[dn ? 2 : 3] == 0,
             cnt[dn ? 3 : 2] > 0, cnt[4] == 0}, 5'h1F);
   endtask
   ///////////////////////////////////////////////////////////////
   // times one full monitor period per note; earlier edges may be mixed
   initial forever begin
      int t0;
      wait (q.size() > 0);
      repeat (2) @(posedge mon);
      t0 = cyc;
      @(posedge mon);
      check(cyc - t0, q[0]);
      void'(q.pop_front());
   end
   initial begin
      int r, a;
      r = $urandom(32'h6CADD6C4);
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      check({fb_side, ref_side, lock, cp_oe}, 4'hA);
      r = 8 + $urandom % 8;
      a = $urandom % 16;
      pls_host_model_inst.send_ref({1'b1, r[13:0], 1'b1});
      q.push_back(r * 8);
      wait (q.size() == 0);
      det(1'b0);
      pol = 1'b0;
      det(1'b1);
      pls_host_model_inst.send_main({11'h010, a[6:0], 1'b0});
      q.push_back((64 * 16 + a) * 4);
      wait (q.size() == 0);
      pls_host_model_inst.send_ref({1'b0, r[13:0], 1'b1});
      q.push_back((128 * 16 + a) * 4);
      wait (q.size() == 0);
      pls_host_model_inst.send_ref({1'b1, r[13:0], 1'b1});
      // reference over twice the feedback period, so phase slip dies in one cycle
      rhalf = 520;
      repeat (24000) @(negedge clk_i);
      det(1'b0);
      pol = 1'b1;
      pls_host_model_inst.drop_strobe();
      det(1'b1);
      end_sim();
   end
endmodule
